/* File: fcb_coef_bank.sv */
// equalizer filter coefficient bank behind an AXI4-Lite slave
//
// Summary of operation
// - Coefficients are signed two's complement in the low twelve bits.
// - Index 0x429 feeds tap nine of channel A, or the single filter.
// - Index 0x448 feeds tap one of the channel B filter.
// - Index 0x44A feeds tap two of the channel B filter.
// - Index 0x44C feeds tap three of the channel B filter.
// - Index 0x44E feeds tap four of the channel B filter.
// - Readback always returns the coefficient MSB as zero.
// - Reset clears every register, reserved bits included.
// - Nine taps per filter; center tap eighteen bits, the rest twelve.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module fcb_coef_bank #(
    parameter int                  ADDR_W = 16
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              dualChannelMode,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic signed [11:0]     chanATap9Coef,
    output logic signed [11:0]     chanBTap1Coef,
    output logic signed [11:0]     chanBTap2Coef,
    output logic signed [11:0]     chanBTap3Coef,
    output logic signed [11:0]     chanBTap4Coef,
    output logic                   chanBTapsInUse
);

    localparam int                 IDX_W = ADDR_W - 2;

    // write side: address and data are caught separately, ready low means held
    logic                          awReady_ff;
    logic [IDX_W-1:0]              wrIdx_ff;
    logic                          wReady_ff;
    fcb_pkg::fcb_wr_t              wrReq_ff;
    logic                          bValid_ff;
    logic [1:0]                    bResp_ff;
    logic                          doWrite;
    logic [fcb_pkg::FCB_REG_NUM-1:0] wrHit;

    // read side
    logic                          arReady_ff;
    logic                          rValid_ff;
    logic [31:0]                   rData_ff;
    logic [1:0]                    rResp_ff;
    logic [IDX_W-1:0]              rdIdx;
    logic [31:0]                   nxt_rData;
    logic                          rdHit;

    logic                          chanBTapsInUse_ff;
    fcb_pkg::fcb_coef_t            regVal [fcb_pkg::FCB_REG_NUM];

    // a write completes only once both halves are held and the last answer is gone
    assign doWrite = !awReady_ff && !wReady_ff && !bValid_ff;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            awReady_ff <= 1'b1;
            wrIdx_ff   <= '0;
        end else if (s_axi_awvalid && awReady_ff) begin
            awReady_ff <= 1'b0;
            wrIdx_ff   <= s_axi_awaddr[ADDR_W-1:2];
        end else if (doWrite) begin
            awReady_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wReady_ff <= 1'b1;
            wrReq_ff  <= '0;
        end else if (s_axi_wvalid && wReady_ff) begin
            wReady_ff     <= 1'b0;
            wrReq_ff.data <= s_axi_wdata[15:0];
            wrReq_ff.strb <= s_axi_wstrb[1:0];
        end else if (doWrite) begin
            wReady_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            bValid_ff <= 1'b0;
            bResp_ff  <= fcb_pkg::FCB_RESP_OKAY;
        end else if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff  <= (|wrHit) ? fcb_pkg::FCB_RESP_OKAY : fcb_pkg::FCB_RESP_SLVERR;
        end else if (bValid_ff && s_axi_bready) begin
            bValid_ff <= 1'b0;
        end
    end

    // upper byte lanes land on bits that read as zero, so they are dropped
    genvar g;
    generate
        for (g = 0; g < fcb_pkg::FCB_REG_NUM; g++) begin : gen_reg
            assign wrHit[g] = (wrIdx_ff == IDX_W'(fcb_pkg::FCB_IDX_TABLE[g]));
            fcb_coef_reg u_reg (
                .core_clk (core_clk),
                .reset    (reset),
                .wrEn     (doWrite && wrHit[g]),
                .wrReq    (wrReq_ff),
                .value    (regVal[g])
            );
        end
    endgenerate

    // the filter sees the full stored sign bit even though readback hides it
    assign chanATap9Coef = regVal[fcb_pkg::FCB_SLOT_A9].coef;
    assign chanBTap1Coef = regVal[fcb_pkg::FCB_SLOT_B1].coef;
    assign chanBTap2Coef = regVal[fcb_pkg::FCB_SLOT_B2].coef;
    assign chanBTap3Coef = regVal[fcb_pkg::FCB_SLOT_B3].coef;
    assign chanBTap4Coef = regVal[fcb_pkg::FCB_SLOT_B4].coef;

    // mode only gates use in the datapath; register contents stay untouched
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chanBTapsInUse_ff <= 1'b0;
        end else begin
            chanBTapsInUse_ff <= dualChannelMode;
        end
    end

    assign rdIdx = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        nxt_rData = fcb_pkg::FCB_RDATA_RST;
        rdHit     = 1'b0;
        for (int i = 0; i < fcb_pkg::FCB_REG_NUM; i++) begin
            if (rdIdx == IDX_W'(fcb_pkg::FCB_IDX_TABLE[i])) begin
                rdHit           = 1'b1;
                nxt_rData[15:0] = regVal[i];
            end
        end
        nxt_rData[fcb_pkg::FCB_COEF_MSB] = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            arReady_ff <= 1'b1;
            rValid_ff  <= 1'b0;
            rData_ff   <= fcb_pkg::FCB_RDATA_RST;
            rResp_ff   <= fcb_pkg::FCB_RESP_OKAY;
        end else if (s_axi_arvalid && arReady_ff) begin
            arReady_ff <= 1'b0;
            rValid_ff  <= 1'b1;
            rData_ff   <= nxt_rData;
            rResp_ff   <= rdHit ? fcb_pkg::FCB_RESP_OKAY : fcb_pkg::FCB_RESP_SLVERR;
        end else if (rValid_ff && s_axi_rready) begin
            arReady_ff <= 1'b1;
            rValid_ff  <= 1'b0;
        end
    end

    assign s_axi_awready  = awReady_ff;
    assign s_axi_wready   = wReady_ff;
    assign s_axi_bvalid   = bValid_ff;
    assign s_axi_bresp    = bResp_ff;
    assign s_axi_arready  = arReady_ff;
    assign s_axi_rvalid   = rValid_ff;
    assign s_axi_rdata    = rData_ff;
    assign s_axi_rresp    = rResp_ff;
    assign chanBTapsInUse = chanBTapsInUse_ff;

    // helper: index of the read in flight, for checking readback against outputs
    logic [IDX_W-1:0]              rdIdxHeld_ff;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdIdxHeld_ff <= '0;
        end else if (s_axi_arvalid && arReady_ff) begin
            rdIdxHeld_ff <= rdIdx;
        end
    end

    readback_low_bits_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(rValid_ff) && rdIdxHeld_ff == IDX_W'(fcb_pkg::FCB_IDX_CHAN_A_TAP9)
        |-> rData_ff[10:0] == $past(chanATap9Coef[10:0])
        && rResp_ff == fcb_pkg::FCB_RESP_OKAY)
        else $error("readback low bits differ from tap nine coefficient");

    tap9_write_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_A9] && wrReq_ff.strb == 2'h3
        |=> chanATap9Coef == $signed($past(wrReq_ff.data[11:0])) && bValid_ff)
        else $error("tap nine coefficient not updated by write");

    b_tap1_write_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_B1] && wrReq_ff.strb == 2'h3
        |=> chanBTap1Coef == $signed($past(wrReq_ff.data[11:0])))
        else $error("channel B tap one not updated by write");

    b_tap2_write_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_B2] && wrReq_ff.strb == 2'h3
        |=> chanBTap2Coef == $signed($past(wrReq_ff.data[11:0])))
        else $error("channel B tap two not updated by write");

    b_tap3_write_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_B3] && wrReq_ff.strb == 2'h3
        |=> chanBTap3Coef == $signed($past(wrReq_ff.data[11:0])))
        else $error("channel B tap three not updated by write");

    b_tap4_write_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_B4] && wrReq_ff.strb == 2'h3
        |=> chanBTap4Coef == $signed($past(wrReq_ff.data[11:0])))
        else $error("channel B tap four not updated by write");

    msb_reads_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        rValid_ff |-> !rData_ff[fcb_pkg::FCB_COEF_MSB] && rData_ff[31:16] == 16'h0000)
        else $error("readback shows coefficient MSB or upper bits set");

    reset_clears_a: assert property (@(posedge core_clk)
        $past(reset) |-> regVal[fcb_pkg::FCB_SLOT_A9] == fcb_pkg::FCB_REG_RST
        && regVal[fcb_pkg::FCB_SLOT_B4] == fcb_pkg::FCB_REG_RST && !bValid_ff && !rValid_ff)
        else $error("coefficient bank not cleared by reset");

    b_taps_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        !dualChannelMode && !doWrite
        |=> $stable(chanBTap1Coef) && $stable(chanBTap4Coef) && !chanBTapsInUse)
        else $error("channel B taps changed without a write in single-channel mode");

    write_answer_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite |=> bValid_ff && awReady_ff && wReady_ff)
        else $error("write answer missing one cycle after completion");

    b1_readback_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(rValid_ff) && rdIdxHeld_ff == IDX_W'(fcb_pkg::FCB_IDX_CHAN_B_TAP1)
        |-> rData_ff[10:0] == $past(chanBTap1Coef[10:0]))
        else $error("readback differs from channel B tap one");

    b2_readback_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(rValid_ff) && rdIdxHeld_ff == IDX_W'(fcb_pkg::FCB_IDX_CHAN_B_TAP2)
        |-> rData_ff[10:0] == $past(chanBTap2Coef[10:0]))
        else $error("readback differs from channel B tap two");

    b3_readback_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(rValid_ff) && rdIdxHeld_ff == IDX_W'(fcb_pkg::FCB_IDX_CHAN_B_TAP3)
        |-> rData_ff[10:0] == $past(chanBTap3Coef[10:0]))
        else $error("readback differs from channel B tap three");

    b4_readback_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(rValid_ff) && rdIdxHeld_ff == IDX_W'(fcb_pkg::FCB_IDX_CHAN_B_TAP4)
        |-> rData_ff[10:0] == $past(chanBTap4Coef[10:0]))
        else $error("readback differs from channel B tap four");

    unmapped_write_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && !(|wrHit)
        |=> bResp_ff == fcb_pkg::FCB_RESP_SLVERR && $stable(chanATap9Coef))
        else $error("unmapped write not refused");

    unmapped_read_a: assert property (@(posedge core_clk) disable iff (reset)
        s_axi_arvalid && arReady_ff && !rdHit
        |=> rData_ff == fcb_pkg::FCB_RDATA_RST && rResp_ff == fcb_pkg::FCB_RESP_SLVERR)
        else $error("unmapped read not refused");

    read_holds_a: assert property (@(posedge core_clk) disable iff (reset)
        rValid_ff && !s_axi_rready
        |=> rValid_ff && $stable(rData_ff) && $stable(rResp_ff))
        else $error("read answer dropped before it was taken");

    resp_holds_a: assert property (@(posedge core_clk) disable iff (reset)
        bValid_ff && !s_axi_bready
        |=> bValid_ff && $stable(bResp_ff))
        else $error("write answer dropped before it was taken");

    read_single_a: assert property (@(posedge core_clk) disable iff (reset)
        rValid_ff
        |-> !arReady_ff)
        else $error("read address open while an answer is pending");

    read_latency_a: assert property (@(posedge core_clk) disable iff (reset)
        s_axi_arvalid && arReady_ff
        |=> rValid_ff)
        else $error("read answer missing one cycle after address");

    tap9_low_byte_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_A9] && wrReq_ff.strb == 2'h1
        |=> chanATap9Coef[7:0] == $past(wrReq_ff.data[7:0]) && $stable(chanATap9Coef[11:8]))
        else $error("low byte write to tap nine wrong");

    tap9_high_byte_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_A9] && wrReq_ff.strb == 2'h2
        |=> chanATap9Coef[11:8] == $past(wrReq_ff.data[11:8]) && $stable(chanATap9Coef[7:0]))
        else $error("high byte write to tap nine wrong");

    tap9_idle_a: assert property (@(posedge core_clk) disable iff (reset)
        !(doWrite && wrHit[fcb_pkg::FCB_SLOT_A9])
        |=> $stable(chanATap9Coef))
        else $error("tap nine changed without a write");

    b_mid_idle_a: assert property (@(posedge core_clk) disable iff (reset)
        !doWrite
        |=> $stable(chanBTap2Coef) && $stable(chanBTap3Coef))
        else $error("channel B taps changed without a write");

    mode_follow_a: assert property (@(posedge core_clk) disable iff (reset)
        1'b1
        |=> chanBTapsInUse == $past(dualChannelMode))
        else $error("channel B use flag does not follow the mode");

    aw_held_a: assert property (@(posedge core_clk) disable iff (reset)
        !awReady_ff && !doWrite
        |=> !awReady_ff)
        else $error("write address reopened before the write completed");

    w_held_a: assert property (@(posedge core_clk) disable iff (reset)
        !wReady_ff && !doWrite
        |=> !wReady_ff)
        else $error("write data reopened before the write completed");

    b_sign_kept_a: assert property (@(posedge core_clk) disable iff (reset)
        doWrite && wrHit[fcb_pkg::FCB_SLOT_B1] && wrReq_ff.strb[1]
        |=> chanBTap1Coef[11] == $past(wrReq_ff.data[11]))
        else $error("sign bit of channel B tap one not stored");

    reserved_readback_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(rValid_ff) && rdIdxHeld_ff == IDX_W'(fcb_pkg::FCB_IDX_CHAN_A_TAP9)
        |-> rData_ff[15:12] == $past(regVal[fcb_pkg::FCB_SLOT_A9].rsvd))
        else $error("reserved bits of tap nine not read back");

    mode_no_touch_a: assert property (@(posedge core_clk) disable iff (reset)
        $changed(dualChannelMode) && !doWrite
        |=> $stable(chanBTap1Coef) && $stable(chanBTap4Coef))
        else $error("mode change disturbed channel B taps");

endmodule : fcb_coef_bank

/* File: fcb_pkg.sv */
// shared constants and types for the equalizer filter coefficient bank
package fcb_pkg;

    // register indices; byte address on the bus is four times the index
    localparam int                 FCB_REG_NUM             = 5;
    localparam int                 FCB_IDX_W               = 14;
    localparam logic [13:0]        FCB_IDX_CHAN_A_TAP9     = 14'h0429;
    localparam logic [13:0]        FCB_IDX_CHAN_B_TAP1     = 14'h0448;
    localparam logic [13:0]        FCB_IDX_CHAN_B_TAP2     = 14'h044A;
    localparam logic [13:0]        FCB_IDX_CHAN_B_TAP3     = 14'h044C;
    localparam logic [13:0]        FCB_IDX_CHAN_B_TAP4     = 14'h044E;
    localparam logic [13:0]        FCB_IDX_TABLE [FCB_REG_NUM] = '{
        FCB_IDX_CHAN_A_TAP9,
        FCB_IDX_CHAN_B_TAP1,
        FCB_IDX_CHAN_B_TAP2,
        FCB_IDX_CHAN_B_TAP3,
        FCB_IDX_CHAN_B_TAP4
    };
    localparam int                 FCB_SLOT_A9             = 0;
    localparam int                 FCB_SLOT_B1             = 1;
    localparam int                 FCB_SLOT_B2             = 2;
    localparam int                 FCB_SLOT_B3             = 3;
    localparam int                 FCB_SLOT_B4             = 4;

    // field layout of one coefficient register
    localparam int                 FCB_REG_W               = 16;
    localparam int                 FCB_COEF_W              = 12;
    localparam int                 FCB_COEF_MSB            = 11;
    localparam int                 FCB_RSVD_LSB            = 12;
    localparam int                 FCB_RSVD_W              = 4;
    localparam int                 FCB_CENTER_COEF_W       = 18;
    localparam int                 FCB_TAP_COUNT           = 9;
    localparam logic [15:0]        FCB_REG_RST             = 16'h0000;

    // bus answers
    localparam logic [1:0]         FCB_RESP_OKAY           = 2'h0;
    localparam logic [1:0]         FCB_RESP_SLVERR         = 2'h2;
    localparam logic [31:0]        FCB_RDATA_RST           = 32'h0000_0000;

    typedef struct packed {
        logic [FCB_RSVD_W-1:0]     rsvd;
        logic signed [FCB_COEF_W-1:0] coef;
    } fcb_coef_t;

    typedef struct packed {
        logic [1:0]                strb;
        logic [FCB_REG_W-1:0]      data;
    } fcb_wr_t;

endpackage : fcb_pkg

/* File: fcb_coef_reg.sv */
// one coefficient register with byte-lane writes
`timescale 1ns/1ps
module fcb_coef_reg (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              wrEn,
    input  fcb_pkg::fcb_wr_t       wrReq,
    output fcb_pkg::fcb_coef_t     value
);

    fcb_pkg::fcb_coef_t            value_ff;
    logic [15:0]                   nxt_value;

    always_comb begin
        nxt_value = value_ff;
        if (wrReq.strb[0]) begin
            nxt_value[7:0] = wrReq.data[7:0];
        end
        if (wrReq.strb[1]) begin
            nxt_value[15:8] = wrReq.data[15:8];
        end
    end

    // reserved bits are kept as written, since they are read/write
    always_ff @(posedge core_clk) begin
        if (reset) begin
            value_ff <= fcb_pkg::FCB_REG_RST;
        end else if (wrEn) begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;

endmodule : fcb_coef_reg

/* File: fcb_coef_bank_bench.sv */
// self-checking bench for the equalizer filter coefficient bank
`timescale 1ns/1ps
module fcb_coef_bank_bench;
    logic               core_clk;
    logic               reset;
    logic               dualChannelMode;
    logic [15:0]        awaddr;
    logic               awvalid;
    logic               awready;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               wvalid;
    logic               wready;
    logic [1:0]         bresp;
    logic               bvalid;
    logic               bready;
    logic [15:0]        araddr;
    logic               arvalid;
    logic               arready;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               rvalid;
    logic               rready;
    logic signed [11:0] coefOut [5];
    logic               chanBTapsInUse;
    logic [15:0]        model [5];
    int                 failures;
    int                 numChecks;
    integer             seed;

    fcb_coef_bank i_fcb_coef_bank (.core_clk(core_clk), .reset(reset),
        .dualChannelMode(dualChannelMode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chanATap9Coef(coefOut[0]), .chanBTap1Coef(coefOut[1]), .chanBTap2Coef(coefOut[2]),
        .chanBTap3Coef(coefOut[3]), .chanBTap4Coef(coefOut[4]),
        .chanBTapsInUse(chanBTapsInUse));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: response %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    task automatic check_coef(input logic [11:0] got, input logic [11:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: coefficient %h expected %h", $time, got, exp);
        end
    endtask : check_coef

    function automatic int slot_of(input logic [15:0] a);
        for (int k = 0; k < 5; k++) if (a[15:2] == fcb_pkg::FCB_IDX_TABLE[k]) return k;
        return -1;
    endfunction : slot_of

    function automatic logic [15:0] addr_of(input int k);
        return {fcb_pkg::FCB_IDX_TABLE[k], 2'b00};
    endfunction : addr_of

    task automatic check_outs;
        for (int k = 0; k < 5; k++) check_coef(coefOut[k], model[k][11:0]);
    endtask : check_outs

    // a dead handshake is left to the watchdog, so no wait assumes a latency
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        logic awDone;
        logic wDone;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awDone = 0;
        wDone = 0;
        forever begin
            @(posedge core_clk);
            if (awDone && wDone && bvalid === 1'b1) break;
            if (!awDone && awready === 1'b1) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        k = slot_of(a);
        check_resp(bresp, (k < 0) ? fcb_pkg::FCB_RESP_SLVERR : fcb_pkg::FCB_RESP_OKAY);
        if (k >= 0 && s[0]) model[k][7:0] = d[7:0];
        if (k >= 0 && s[1]) model[k][15:8] = d[15:8];
        check_outs();
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a);
        int k;
        logic arDone;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        arDone = 0;
        forever begin
            @(posedge core_clk);
            if (arDone && rvalid === 1'b1) break;
            if (!arDone && arready === 1'b1) begin
                arDone = 1;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        k = slot_of(a);
        check_resp(rresp, (k < 0) ? fcb_pkg::FCB_RESP_SLVERR : fcb_pkg::FCB_RESP_OKAY);
        check_word(rdata, (k < 0) ? 32'h0 : {16'h0, model[k][15:12], 1'b0, model[k][10:0]});
    endtask : axi_read

    task automatic set_mode(input logic v);
        logic old;
        old = dualChannelMode;
        @(posedge core_clk);
        dualChannelMode <= v;
        @(negedge core_clk);
        check_word({31'h0, chanBTapsInUse}, {31'h0, old});
        @(negedge core_clk);
        check_word({31'h0, chanBTapsInUse}, {31'h0, v});
    endtask : set_mode

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        int r;
        seed = 32'hD75B6FFF;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
        dualChannelMode = 1'b0;
        reset = 1'b1;
        failures = 0;
        numChecks = 0;
        foreach (model[k]) model[k] = 16'h0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        for (int k = 0; k < 5; k++) axi_read(addr_of(k));
        check_outs();
        check_word($bits(coefOut[0]), fcb_pkg::FCB_COEF_W);
        for (int k = 0; k < 5; k++) begin
            axi_write(addr_of(k), $random(seed) | 32'h0800, 4'hF);
            axi_read(addr_of(k));
            axi_write(addr_of(k), $random(seed), 4'h1);
            axi_write(addr_of(k), $random(seed), 4'h2);
            axi_write(addr_of(k), $random(seed), 4'h0);
            axi_read(addr_of(k));
        end
        axi_write(16'h10A8, $random(seed), 4'hF);
        axi_read(16'h10A8);
        set_mode(1'b1);
        set_mode(1'b0);
        axi_write(addr_of(2), 32'h0000_FFFF, 4'hF);
        set_mode(1'b1);
        axi_read(addr_of(2));
        repeat (80) begin
            r = $random(seed);
            if (r[2:0] == 3'h7) set_mode(r[3]);
            else if (r[4]) axi_write((r[7:5] < 5) ? addr_of(r[7:5]) : r[31:16], $random(seed),
                                     r[11:8]);
            else axi_read((r[7:5] < 5) ? addr_of(r[7:5]) : r[31:16]);
        end
        // a second reset in mid-run must clear everything, mode input held high meanwhile
        @(posedge core_clk);
        reset <= 1'b1;
        dualChannelMode <= 1'b1;
        foreach (model[k]) model[k] = 16'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check_word({31'h0, chanBTapsInUse}, 32'h0);
        check_outs();
        @(posedge core_clk);
        reset <= 1'b0;
        for (int k = 0; k < 5; k++) axi_read(addr_of(k));
        report_and_stop();
    end
endmodule : fcb_coef_bank_bench
